/* pcrs_core.sv */
// Program counter with latch registers and hardware return address stack
`timescale 1ns/1ps
`default_nettype none

module pcrs_core #(
   parameter int IMPL_BYTES = pcrs_pkg::IMPL_BYTES
) (
   // Clock and reset
   input  wire logic                           i_clock,
   input  wire logic                           i_rst,
   // Configuration
   input  wire logic                           i_overflow_reset_enable,
   // Core sequencing requests
   input  wire pcrs_pkg::pcrs_core_req_s       i_core_req,
   // Program memory
   input  wire logic [pcrs_pkg::INSTR_W-1:0]   i_mem_word,
   output logic [pcrs_pkg::PC_W-1:0]           o_pc,
   output logic [pcrs_pkg::INSTR_W-1:0]        o_instr_word,
   // Stack reset request
   output logic                                o_stack_reset,
   // Register port
   input  wire logic [pcrs_pkg::ADDR_W-1:0]    i_addr,
   input  wire logic [7:0]                     i_wdata,
   input  wire logic                           i_wr,
   input  wire logic                           i_rd,
   output logic [7:0]                          o_rdata
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   // 31 entries, 5-bit pointer
   pcrs_pkg::pcrs_state_s state_reg;
   pcrs_pkg::pcrs_state_s state_next;
   logic                  bus_pc_wr;
   logic                  bus_pc_rd;
   logic                  bus_ptr_wr;
   logic                  bus_tos_wr;
   logic                  bus_latch_wr;
   logic                  full_set;
   logic                  unf_set;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Addressed entry only
   function automatic logic [pcrs_pkg::PC_W-1:0] top_of(input pcrs_pkg::pcrs_state_s st);
      logic [pcrs_pkg::PC_W-1:0] v;
      v = '0;
      if (st.pointer_field != pcrs_pkg::PTR_EMPTY) begin
         v = st.stack[st.pointer_field];
      end
      return v;
   endfunction : top_of

   function automatic pcrs_pkg::pcrs_state_s do_push(input pcrs_pkg::pcrs_state_s st,
                                                      input logic [pcrs_pkg::PC_W-1:0] v,
                                                      input logic ovf_en);
      pcrs_pkg::pcrs_state_s r;
      r = st;
      if (st.pointer_field == pcrs_pkg::PTR_LAST) begin
         r.stack_full_flag = 1'b1;
      end else if (st.pointer_field == pcrs_pkg::PTR_PRE_FULL) begin
         r.stack_full_flag = 1'b1;
         if (ovf_en) begin
            // Store PC plus two and reset
            r.stack[pcrs_pkg::PTR_LAST] = v + pcrs_pkg::PC_STEP;
            r.pointer_field = pcrs_pkg::PTR_EMPTY;
            r.pc = pcrs_pkg::RESET_VECTOR;
            r.pc_high_latch = '0;
            r.pc_upper_latch = '0;
            r.ovf_reset = 1'b1;
         end else begin
            r.stack[pcrs_pkg::PTR_LAST] = v;
            r.pointer_field = pcrs_pkg::PTR_LAST;
         end
      end else begin
         r.pointer_field = st.pointer_field + 5'h01;
         r.stack[r.pointer_field] = v;
      end
      return r;
   endfunction : do_push

   function automatic pcrs_pkg::pcrs_state_s do_pop(input pcrs_pkg::pcrs_state_s st,
                                                     input logic load_pc);
      pcrs_pkg::pcrs_state_s r;
      r = st;
      if (st.pointer_field == pcrs_pkg::PTR_EMPTY) begin
         r.stack_underflow_flag = 1'b1;
         if (load_pc) begin
            r.pc = pcrs_pkg::RESET_VECTOR;
         end
      end else begin
         if (load_pc) begin
            r.pc = st.stack[st.pointer_field];
         end
         r.pointer_field = st.pointer_field - 5'h01;
      end
      return r;
   endfunction : do_pop

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   assign bus_pc_wr    = i_wr && (i_addr == pcrs_pkg::REG_PC_LOW_BYTE);
   assign bus_pc_rd    = i_rd && (i_addr == pcrs_pkg::REG_PC_LOW_BYTE);
   assign bus_ptr_wr   = i_wr && (i_addr == pcrs_pkg::REG_STACK_POINTER);
   assign bus_latch_wr = i_wr && ((i_addr == pcrs_pkg::REG_PC_HIGH_LATCH) ||
                                  (i_addr == pcrs_pkg::REG_PC_UPPER_LATCH));
   assign bus_tos_wr   = i_wr && ((i_addr == pcrs_pkg::REG_TOP_LOW) ||
                                  (i_addr == pcrs_pkg::REG_TOP_HIGH) ||
                                  (i_addr == pcrs_pkg::REG_TOP_UPPER));

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [pcrs_pkg::PC_W-1:0] top;
      top = '0;
      state_next = state_reg;
      state_next.ovf_reset = 1'b0;
      state_next.rdata = '0;
      if (state_reg.pc < IMPL_BYTES) begin
         state_next.instr = i_mem_word;
      end else begin
         state_next.instr = '0;
      end

      unique case (i_core_req.op)
         pcrs_pkg::OP_NONE: begin
         end
         pcrs_pkg::OP_STEP: begin
            state_next.pc = state_reg.pc + pcrs_pkg::PC_STEP;
         end
         pcrs_pkg::OP_JUMP: begin
            state_next.pc = i_core_req.target & pcrs_pkg::PC_ALIGN_MASK;
         end
         pcrs_pkg::OP_CALL: begin
            state_next.pc = i_core_req.target & pcrs_pkg::PC_ALIGN_MASK;
            state_next = do_push(state_next, state_reg.pc, i_overflow_reset_enable);
         end
         pcrs_pkg::OP_INT_ACK: begin
            state_next.pc = i_core_req.high_prio ? pcrs_pkg::HIGH_INT_VECTOR : pcrs_pkg::LOW_INT_VECTOR;
            state_next = do_push(state_next, state_reg.pc, i_overflow_reset_enable);
         end
         pcrs_pkg::OP_RETURN: begin
            state_next = do_pop(state_next, 1'b1);
         end
         pcrs_pkg::OP_SW_PUSH: begin
            state_next = do_push(state_next, state_reg.pc, i_overflow_reset_enable);
         end
         pcrs_pkg::OP_SW_POP: begin
            state_next = do_pop(state_next, 1'b0);
         end
         default: begin
         end
      endcase

      full_set = state_next.stack_full_flag & ~state_reg.stack_full_flag;
      unf_set  = state_next.stack_underflow_flag & ~state_reg.stack_underflow_flag;

      // Register writes
      if (i_wr) begin
         unique case (i_addr)
            pcrs_pkg::REG_PC_LOW_BYTE: begin
               state_next.pc = {state_reg.pc_upper_latch, state_reg.pc_high_latch,
                                i_wdata[7:1], 1'b0};
            end
            pcrs_pkg::REG_PC_HIGH_LATCH: begin
               state_next.pc_high_latch = i_wdata;
            end
            pcrs_pkg::REG_PC_UPPER_LATCH: begin
               state_next.pc_upper_latch = i_wdata[4:0];
            end
            pcrs_pkg::REG_STACK_POINTER: begin
               state_next.pointer_field = i_wdata[pcrs_pkg::PTR_W-1:0];
               state_next.stack_full_flag = (state_reg.stack_full_flag & i_wdata[pcrs_pkg::FULL_BIT]) |
                                            full_set;
               state_next.stack_underflow_flag =
                  (state_reg.stack_underflow_flag & i_wdata[pcrs_pkg::UNDERFLOW_BIT]) | unf_set;
            end
            pcrs_pkg::REG_TOP_LOW: begin
               if (state_next.pointer_field != pcrs_pkg::PTR_EMPTY) begin
                  state_next.stack[state_next.pointer_field][7:0] = i_wdata;
               end
            end
            pcrs_pkg::REG_TOP_HIGH: begin
               if (state_next.pointer_field != pcrs_pkg::PTR_EMPTY) begin
                  state_next.stack[state_next.pointer_field][15:8] = i_wdata;
               end
            end
            pcrs_pkg::REG_TOP_UPPER: begin
               if (state_next.pointer_field != pcrs_pkg::PTR_EMPTY) begin
                  state_next.stack[state_next.pointer_field][20:16] = i_wdata[4:0];
               end
            end
            default: begin
            end
         endcase
      end

      // Register reads
      if (i_rd) begin
         top = top_of(state_reg);
         unique case (i_addr)
            pcrs_pkg::REG_PC_LOW_BYTE: begin
               state_next.rdata = state_reg.pc[7:0];
               state_next.pc_high_latch  = state_reg.pc[15:8];
               state_next.pc_upper_latch = state_reg.pc[20:16];
            end
            pcrs_pkg::REG_PC_HIGH_LATCH: begin
               state_next.rdata = state_reg.pc_high_latch;
            end
            pcrs_pkg::REG_PC_UPPER_LATCH: begin
               state_next.rdata = {3'h0, state_reg.pc_upper_latch};
            end
            pcrs_pkg::REG_STACK_POINTER: begin
               state_next.rdata = {state_reg.stack_full_flag, state_reg.stack_underflow_flag,
                                   1'b0, state_reg.pointer_field};
            end
            pcrs_pkg::REG_TOP_LOW: begin
               state_next.rdata = top[7:0];
            end
            pcrs_pkg::REG_TOP_HIGH: begin
               state_next.rdata = top[15:8];
            end
            pcrs_pkg::REG_TOP_UPPER: begin
               state_next.rdata = {3'h0, top[20:16]};
            end
            default: begin
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_pc          = state_reg.pc;
   assign o_instr_word  = state_reg.instr;
   assign o_stack_reset = state_reg.ovf_reset;
   assign o_rdata       = state_reg.rdata;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   logic is_push;
   assign is_push = (i_core_req.op == pcrs_pkg::OP_CALL) || (i_core_req.op == pcrs_pkg::OP_INT_ACK) ||
                    (i_core_req.op == pcrs_pkg::OP_SW_PUSH);

   pc_aligned_a: assert property (state_reg.pc[0] == 1'b0)
      else $error("Counter bit 0 not zero");

   step_by_two_a: assert property ((i_core_req.op == pcrs_pkg::OP_STEP) && !bus_pc_wr
      |=> state_reg.pc == $past(state_reg.pc) + pcrs_pkg::PC_STEP)
      else $error("Sequential step not two");

   pcl_write_load_a: assert property (bus_pc_wr
      |=> state_reg.pc == {$past(state_reg.pc_upper_latch), $past(state_reg.pc_high_latch),
                           $past(i_wdata[7:1]), 1'b0})
      else $error("Low byte write did not load latches");

   pcl_read_latch_a: assert property (bus_pc_rd && !i_wr
      |=> state_reg.pc_high_latch == $past(state_reg.pc[15:8]) &&
          state_reg.pc_upper_latch == $past(state_reg.pc[20:16]))
      else $error("Low byte read did not fill latches");

   latch_stable_a: assert property ((i_core_req.op inside {pcrs_pkg::OP_CALL, pcrs_pkg::OP_RETURN})
      && !bus_pc_rd && !bus_latch_wr && !(is_push && i_overflow_reset_enable &&
      state_reg.pointer_field == pcrs_pkg::PTR_PRE_FULL)
      |=> $stable(state_reg.pc_high_latch) && $stable(state_reg.pc_upper_latch))
      else $error("Call or return changed a latch");

   push_order_a: assert property (is_push && state_reg.pointer_field < pcrs_pkg::PTR_PRE_FULL
      && !bus_ptr_wr && !bus_tos_wr
      |=> state_reg.pointer_field == $past(state_reg.pointer_field) + 5'h01 &&
          top_of(state_reg) == $past(state_reg.pc))
      else $error("Push did not increment and store");

   pop_order_a: assert property ((i_core_req.op == pcrs_pkg::OP_RETURN) &&
      state_reg.pointer_field != pcrs_pkg::PTR_EMPTY && !bus_ptr_wr && !bus_pc_wr
      |=> state_reg.pc == $past(top_of(state_reg)) &&
          state_reg.pointer_field == $past(state_reg.pointer_field) - 5'h01)
      else $error("Pop did not load and decrement");

   underflow_a: assert property ((i_core_req.op == pcrs_pkg::OP_RETURN) &&
      state_reg.pointer_field == pcrs_pkg::PTR_EMPTY && !bus_ptr_wr && !bus_pc_wr
      |=> state_reg.stack_underflow_flag && state_reg.pc == pcrs_pkg::RESET_VECTOR &&
          state_reg.pointer_field == pcrs_pkg::PTR_EMPTY && !o_stack_reset)
      else $error("Underflow handled wrongly");

   overflow_reset_a: assert property (is_push && i_overflow_reset_enable && !bus_ptr_wr &&
      state_reg.pointer_field == pcrs_pkg::PTR_PRE_FULL
      |=> o_stack_reset && state_reg.stack_full_flag && state_reg.pointer_field == pcrs_pkg::PTR_EMPTY
      ##1 !o_stack_reset)
      else $error("Overflow reset sequence wrong");

   full_hold_a: assert property (is_push && !i_overflow_reset_enable && !bus_ptr_wr && !bus_tos_wr &&
      state_reg.pointer_field == pcrs_pkg::PTR_LAST
      |=> state_reg.pointer_field == pcrs_pkg::PTR_LAST && $stable(state_reg.stack[pcrs_pkg::PTR_LAST]))
      else $error("Entry 31 or pointer changed when full");

   flag_no_set_a: assert property (!state_reg.stack_full_flag && !full_set && bus_ptr_wr
      |=> !state_reg.stack_full_flag)
      else $error("Software set the full flag");

   unf_no_set_a: assert property (!state_reg.stack_underflow_flag && !unf_set && bus_ptr_wr
      |=> !state_reg.stack_underflow_flag)
      else $error("Software set the underflow flag");

   int_vector_a: assert property ((i_core_req.op == pcrs_pkg::OP_INT_ACK) && i_core_req.high_prio
      && !bus_pc_wr && state_reg.pointer_field < pcrs_pkg::PTR_PRE_FULL
      |=> state_reg.pc == pcrs_pkg::HIGH_INT_VECTOR)
      else $error("High interrupt vector wrong");

   ptr_read_a: assert property (i_rd && i_addr == pcrs_pkg::REG_STACK_POINTER
      |=> o_rdata[4:0] == $past(state_reg.pointer_field) && o_rdata[5] == 1'b0)
      else $error("Pointer read wrong");

   cover_overflow_c: cover property (o_stack_reset);
   cover_underflow_c: cover property ($rose(state_reg.stack_underflow_flag));
   cover_pcl_write_c: cover property (bus_pc_wr);
   cover_nested_c: cover property (is_push ##1 is_push ##1 i_core_req.op == pcrs_pkg::OP_RETURN);

endmodule : pcrs_core

`default_nettype wire

/* pcrs_fetch_model.sv */
// Sequencer and program memory model facing the counter and stack block
`timescale 1ns/1ps
`default_nettype none
module pcrs_fetch_model (
   // Program counter from the block
   input  wire logic [pcrs_pkg::PC_W-1:0]  i_pc,
   // Sequencer commands from the bench
   input  wire pcrs_pkg::pcrs_op_e         i_op,
   input  wire logic [pcrs_pkg::PC_W-1:0]  i_target,
   input  wire logic                       i_high_prio,
   input  wire logic                       i_stack_access,
   // Requests and fetched word to the block
   output pcrs_pkg::pcrs_core_req_s        o_core_req,
   output logic [pcrs_pkg::INSTR_W-1:0]    o_mem_word
);
   // ---------------------------------------------------------------
   // Request packing
   // ---------------------------------------------------------------
   always_comb begin
      o_core_req.op        = i_op;
      o_core_req.target    = i_target;
      o_core_req.high_prio = i_high_prio;
      if (i_stack_access && i_op == pcrs_pkg::OP_INT_ACK) begin
         o_core_req.op = pcrs_pkg::OP_NONE;
      end
   end
   // Program memory contents follow the word address
   assign o_mem_word = i_pc[16:1] ^ 16'h5a5a;
endmodule : pcrs_fetch_model
`default_nettype wire

/* pcrs_pkg.sv */
// Shared constants and types for the program counter and return stack block
package pcrs_pkg;

   // ---------------------------------------------------------------
   // Widths and sizes
   // ---------------------------------------------------------------
   localparam int PC_W          = 21;
   localparam int PTR_W         = 5;
   localparam int ADDR_W        = 3;
   localparam int STACK_DEPTH   = 31;
   localparam int IMPL_BYTES    = 8192;
   localparam int INSTR_W       = 16;

   // ---------------------------------------------------------------
   // Register indices
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_PC_LOW_BYTE   = 3'h0;
   localparam logic [ADDR_W-1:0] REG_PC_HIGH_LATCH = 3'h1;
   localparam logic [ADDR_W-1:0] REG_PC_UPPER_LATCH = 3'h2;
   localparam logic [ADDR_W-1:0] REG_STACK_POINTER = 3'h3;
   localparam logic [ADDR_W-1:0] REG_TOP_LOW       = 3'h4;
   localparam logic [ADDR_W-1:0] REG_TOP_HIGH      = 3'h5;
   localparam logic [ADDR_W-1:0] REG_TOP_UPPER     = 3'h6;

   // ---------------------------------------------------------------
   // Field positions and values
   // ---------------------------------------------------------------
   localparam int FULL_BIT      = 7;
   localparam int UNDERFLOW_BIT = 6;
   localparam logic [PTR_W-1:0] PTR_EMPTY = 5'h00;
   localparam logic [PTR_W-1:0] PTR_LAST  = 5'h1f;
   localparam logic [PTR_W-1:0] PTR_PRE_FULL = 5'h1e;
   localparam logic [PC_W-1:0]  RESET_VECTOR   = 21'h000000;
   localparam logic [PC_W-1:0]  HIGH_INT_VECTOR = 21'h000008;
   localparam logic [PC_W-1:0]  LOW_INT_VECTOR  = 21'h000018;
   localparam logic [PC_W-1:0]  PC_STEP        = 21'h000002;
   localparam logic [PC_W-1:0]  PC_ALIGN_MASK  = 21'h1ffffe;

   // ---------------------------------------------------------------
   // Core requests
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NONE     = 4'h0,
      OP_STEP     = 4'h1,
      OP_JUMP     = 4'h2,
      OP_CALL     = 4'h3,
      OP_INT_ACK  = 4'h4,
      OP_RETURN   = 4'h5,
      OP_SW_PUSH  = 4'h6,
      OP_SW_POP   = 4'h7
   } pcrs_op_e;

   typedef struct packed {
      pcrs_op_e         op;
      logic [PC_W-1:0]  target;
      logic             high_prio;
   } pcrs_core_req_s;

   typedef struct packed {
      logic [PC_W-1:0]                     pc;
      logic [7:0]                          pc_high_latch;
      logic [4:0]                          pc_upper_latch;
      logic [PTR_W-1:0]                    pointer_field;
      logic                                stack_full_flag;
      logic                                stack_underflow_flag;
      logic [STACK_DEPTH:1][PC_W-1:0]      stack;
      logic [7:0]                          rdata;
      logic [INSTR_W-1:0]                  instr;
      logic                                ovf_reset;
   } pcrs_state_s;

endpackage : pcrs_pkg

/* tb_pcrs_core.sv */
// Self-checking bench for the counter and return stack block
`timescale 1ns/1ps
`default_nettype none
module tb_pcrs_core;
   logic                     i_clock, i_rst, ovf_en, wr, rd, stk_acc, hp, stk_rst;
   logic [2:0]               addr;
   logic [7:0]               wdata, rdata;
   logic [20:0]              pc, tgt;
   logic [15:0]              mem_word, instr;
   pcrs_pkg::pcrs_op_e       op;
   pcrs_pkg::pcrs_core_req_s req;
   int                       err_total = 0;
   int                       compares = 0;
   pcrs_fetch_model i_pcrs_fetch_model (.i_pc(pc), .i_op(op), .i_target(tgt), .i_high_prio(hp),
      .i_stack_access(stk_acc), .o_core_req(req), .o_mem_word(mem_word));
   pcrs_core i_pcrs_core (.i_clock(i_clock), .i_rst(i_rst), .i_overflow_reset_enable(ovf_en),
      .i_core_req(req), .i_mem_word(mem_word), .o_pc(pc), .o_instr_word(instr),
      .o_stack_reset(stk_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic test_done;
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [20:0] got, input logic [20:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic core(input pcrs_pkg::pcrs_op_e o, input logic [20:0] t);
      @(posedge i_clock);
      op  <= o;
      tgt <= t;
      @(posedge i_clock);
      op  <= pcrs_pkg::OP_NONE;
      #1;
   endtask : core
   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clock);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge i_clock);
      wr <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge i_clock);
      addr <= a;
      rd   <= 1'b1;
      @(posedge i_clock);
      rd <= 1'b0;
      #1;
      chk({13'h0, rdata}, {13'h0, exp});
   endtask : reg_rd
   task automatic top_chk(input logic [20:0] exp);
      reg_rd(3'h4, exp[7:0]);
      reg_rd(3'h5, exp[15:8]);
      reg_rd(3'h6, {3'h0, exp[20:16]});
   endtask : top_chk
   task automatic fill(input int n);
      core(pcrs_pkg::OP_JUMP, 21'h0);
      for (int k = 0; k < n; k++) begin
         core(pcrs_pkg::OP_CALL, 21'((k + 1) * 4));
      end
   endtask : fill
   task automatic rst;
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clock);
      i_rst <= 1'b0;
   endtask : rst
   // ---------------------------------------------------------------
   // Clock, watchdog and tests
   // ---------------------------------------------------------------
   initial begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end
   initial begin
      repeat (20000) @(posedge i_clock);
      err_total++;
      test_done();
   end
   initial begin
      {wr, rd, stk_acc, hp, addr, wdata, tgt} = '0;
      op = pcrs_pkg::OP_NONE;
      ovf_en = 1'b1;
      rst();
      reg_rd(3'h3, 8'h00);
      chk(pc, 21'h0);
      core(pcrs_pkg::OP_STEP, 21'h0);
      core(pcrs_pkg::OP_STEP, 21'h0);
      chk(pc, 21'h4);
      core(pcrs_pkg::OP_JUMP, 21'h12345);
      chk(pc, 21'h12344);
      reg_wr(3'h1, 8'hab);
      reg_wr(3'h2, 8'h1c);
      core(pcrs_pkg::OP_CALL, 21'h200);
      chk(pc, 21'h200);
      reg_rd(3'h3, 8'h01);
      top_chk(21'h12344);
      hp <= 1'b1;
      core(pcrs_pkg::OP_INT_ACK, 21'h0);
      chk(pc, 21'h8);
      hp <= 1'b0;
      core(pcrs_pkg::OP_INT_ACK, 21'h0);
      chk(pc, 21'h18);
      top_chk(21'h8);
      core(pcrs_pkg::OP_RETURN, 21'h0);
      chk(pc, 21'h8);
      reg_rd(3'h3, 8'h02);
      core(pcrs_pkg::OP_RETURN, 21'h0);
      core(pcrs_pkg::OP_RETURN, 21'h0);
      chk(pc, 21'h12344);
      core(pcrs_pkg::OP_RETURN, 21'h0);
      chk(pc, 21'h0);
      reg_rd(3'h3, 8'h40);
      reg_rd(3'h1, 8'hab);
      reg_rd(3'h2, 8'h1c);
      reg_wr(3'h3, 8'h00);
      reg_wr(3'h3, 8'hdf);
      reg_rd(3'h3, 8'h1f);
      reg_wr(3'h3, 8'h00);
      reg_wr(3'h1, 8'h12);
      reg_wr(3'h2, 8'h03);
      reg_wr(3'h0, 8'h57);
      #1;
      chk(pc, 21'h031256);
      reg_wr(3'h1, 8'h00);
      reg_wr(3'h2, 8'h00);
      reg_rd(3'h0, 8'h56);
      reg_rd(3'h1, 8'h12);
      reg_rd(3'h2, 8'h03);
      core(pcrs_pkg::OP_JUMP, 21'h100);
      @(posedge i_clock);
      #1;
      chk({5'h0, instr}, 21'h5ada);
      core(pcrs_pkg::OP_JUMP, 21'h4000);
      @(posedge i_clock);
      #1;
      chk({5'h0, instr}, 21'h0);
      stk_acc <= 1'b1;
      core(pcrs_pkg::OP_CALL, 21'h300);
      reg_wr(3'h4, 8'h0a);
      reg_wr(3'h5, 8'h0b);
      reg_wr(3'h6, 8'h01);
      core(pcrs_pkg::OP_INT_ACK, 21'h0);
      chk(pc, 21'h300);
      stk_acc <= 1'b0;
      core(pcrs_pkg::OP_RETURN, 21'h0);
      chk(pc, 21'h010b0a);
      core(pcrs_pkg::OP_SW_PUSH, 21'h0);
      top_chk(21'h010b0a);
      core(pcrs_pkg::OP_SW_POP, 21'h0);
      chk(pc, 21'h010b0a);
      reg_rd(3'h3, 8'h00);
      ovf_en <= 1'b0;
      fill(31);
      reg_rd(3'h3, 8'h9f);
      top_chk(21'h78);
      core(pcrs_pkg::OP_CALL, 21'h400);
      reg_rd(3'h3, 8'h9f);
      top_chk(21'h78);
      ovf_en <= 1'b1;
      rst();
      reg_rd(3'h3, 8'h00);
      fill(31);
      chk({20'h0, stk_rst}, 21'h1);
      chk(pc, 21'h0);
      reg_rd(3'h3, 8'h80);
      reg_wr(3'h3, 8'h9f);
      top_chk(21'h7a);
      test_done();
   end
endmodule : tb_pcrs_core
`default_nettype wire
